// ===== hw/ors_pkg.sv
package ors_pkg;
  localparam int FREQ_W = 16;
  localparam int CLK_HZ = 25000000;
  // timebase tick of 1 ms
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
  localparam int TIME_W = 16;
  localparam logic [TIME_W-1:0] RUN_WAIT_MS = 16'h07d0;
  localparam logic [TIME_W-1:0] OUTAGE_MAX_MS = 16'h7530;
  // restart mode codes
  localparam logic [2:0] MODE_TRIP_NOW = 3'h0;
  localparam logic [2:0] MODE_TRIP_LATER = 3'h1;
  localparam logic [2:0] MODE_SAVED_FREQ = 3'h4;
  localparam logic [2:0] MODE_START_FREQ = 3'h5;
  localparam logic [1:0] SRC_FIXED_FWD = 2'h2;
  localparam logic [1:0] SRC_FIXED_REV = 2'h3;
  // cycles a pin level needs to cross the two-stage synchroniser
  localparam logic [1:0] SYNC_CYC = 2'h2;
  // axi-lite byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TIMES = 8'h04;
  localparam logic [7:0] REG_START_FREQ = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [7:0] REG_FREQ = 8'h18;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] TIMES_RESET = 32'h01f40000;
  localparam logic [15:0] START_FREQ_RESET = 16'h0032;
  localparam int IRQ_W = 4;
  localparam int IRQ_FAIL = 0;
  localparam int IRQ_ALARM = 1;
  localparam int IRQ_RESTART = 2;
  localparam int IRQ_CANCEL = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN, ST_FAIL, ST_CHARGE, ST_WAIT_RUN, ST_RESTART, ST_TRIP
  } ors_state_type;
  typedef struct packed {
    logic uv;
    logic ready;
    logic run_cmd;
    logic coast;
    logic i_limit;
  } ors_drive_in_type;
  typedef struct packed {
    logic out_enable;
    logic uv_alarm;
    logic pending;
    logic restart;
    logic [FREQ_W-1:0] freq;
  } ors_drive_out_type;
endpackage

// ===== hw/ors_sequencer.sv
// What this block does
// RULE_01 - Mode 0 raises the undervoltage alarm and cuts the output the moment undervoltage hits.
// RULE_02 - Mode 1 cuts the output on undervoltage silently and raises the alarm only on recovery.
// RULE_03 - Mode 4 saves the running output frequency at failure and then cuts the output.
// RULE_04 - Mode 4 restarts at the saved frequency when a run command is present after recovery.
// RULE_05 - Mode 5 restarts at the starting frequency setting after recovery and a run command.
// RULE_06 - Undervoltage counts as a power failure only while running.
// RULE_07 - A failure holds restart pending; recovery passes a charging stage before ready-to-run.
// RULE_08 - After ready-to-run the block waits up to 2 s for a run command, then restarts per mode.
// RULE_09 - No run command within 2 s cancels restart pending and needs a normal start.
// RULE_10 - With a fixed-direction run source (2 or 3) restart begins at once on ready-to-run.
// RULE_11 - With keypad run source 0 the outside must still give a run command within the window.
// RULE_12 - Expiry of the allowable outage time cancels a pending restart even inside the window.
// RULE_13 - Coast-stop during the failure cancels restart pending; the next start is normal.
// RULE_14 - On restart at the saved frequency current limit lowers it, then it climbs back.
// RULE_15 - Allowable outage time is 0.0 to 30.0 s; later recovery gives a normal start.
// RULE_16 - Restart waits until the restart delay since failure has elapsed.
// RULE_17 - The failure and run-wait windows each have a ms counter advanced by one fixed timebase tick.
module ors_sequencer #(
  parameter int TICK_CYCLES = ors_pkg::TICK_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_uv,
  input wire logic i_ready,
  input wire logic i_run_cmd,
  input wire logic i_coast_stop_command,
  input wire logic i_current_limit,
  input wire logic [ors_pkg::FREQ_W-1:0] i_out_freq,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic o_out_enable,
  output logic o_uv_alarm,
  output logic o_restart_pending,
  output logic o_restart,
  output logic [ors_pkg::FREQ_W-1:0] o_freq_ref,
  output logic o_irq
);
  // pin synchronisers: first stage feeds only the second
  ors_pkg::ors_drive_in_type pin_s1, pin_s2, din;
  ors_pkg::ors_drive_out_type dout, next_dout;
  ors_pkg::ors_state_type state, next_state;
  assign din = pin_s2;

  // control regs: [2:0] mode, [5:4] run source, [8] overcurrent limit enable
  logic [31:0] ctrl, next_ctrl;
  // times: [15:0] allowable outage ms, [31:16] restart delay ms
  logic [31:0] times, next_times;
  logic [15:0] start_freq, next_start_freq;
  logic [ors_pkg::IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic [ors_pkg::IRQ_W-1:0] irq_evt;

  logic [2:0] mode;
  logic [1:0] run_src;
  logic ocl_en;
  logic [15:0] outage_ms;
  logic [15:0] delay_ms;
  assign mode = ctrl[2:0];
  assign run_src = ctrl[5:4];
  assign ocl_en = ctrl[8];
  assign outage_ms = (times[15:0] > ors_pkg::OUTAGE_MAX_MS) ? ors_pkg::OUTAGE_MAX_MS
                                                            : times[15:0];
  assign delay_ms = times[31:16];

  // timebase
  logic [15:0] div_cnt, next_div_cnt;
  logic tick;
  assign tick = (div_cnt == 16'(TICK_CYCLES - 1));
  // one ms counter since failure, one since ready-to-run
  logic [ors_pkg::TIME_W-1:0] fail_ms, next_fail_ms, wait_ms, next_wait_ms;
  logic [ors_pkg::FREQ_W-1:0] saved_freq, next_saved_freq, target_freq, next_target_freq;
  logic [1:0] settle, next_settle;
  logic fixed_src;
  logic outage_over;
  assign fixed_src = (run_src == ors_pkg::SRC_FIXED_FWD) || (run_src == ors_pkg::SRC_FIXED_REV);
  assign outage_over = (fail_ms >= outage_ms);

  function automatic logic [ors_pkg::TIME_W-1:0] sat_inc(input logic [ors_pkg::TIME_W-1:0] v);
    sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  always_comb begin
    next_state = state;
    next_dout = dout;
    next_div_cnt = tick ? 16'h0000 : div_cnt + 16'h0001; // [RULE_17]
    next_fail_ms = (tick && state != ors_pkg::ST_RUN) ? sat_inc(fail_ms) : fail_ms;
    next_wait_ms = (tick && state == ors_pkg::ST_WAIT_RUN) ? sat_inc(wait_ms) : wait_ms;
    next_saved_freq = saved_freq;
    next_target_freq = target_freq;
    next_settle = settle;
    irq_evt = '0;
    next_dout.restart = 1'b0;
    unique case (state)
      ors_pkg::ST_IDLE: begin
        next_dout.out_enable = 1'b0;
        next_dout.pending = 1'b0;
        if (din.run_cmd && din.ready && !din.uv && !din.coast) begin
          next_state = ors_pkg::ST_RUN;
          next_dout.freq = start_freq;
          next_dout.out_enable = 1'b1;
          next_dout.uv_alarm = 1'b0;
        end
      end
      ors_pkg::ST_RUN: begin
        next_dout.freq = i_out_freq;
        if (!din.run_cmd || din.coast) begin
          next_state = ors_pkg::ST_IDLE;
          next_dout.out_enable = 1'b0;
        end else if (din.uv) begin // [RULE_06]
          next_dout.out_enable = 1'b0;
          next_fail_ms = '0;
          irq_evt[ors_pkg::IRQ_FAIL] = 1'b1;
          if (mode == ors_pkg::MODE_TRIP_NOW) begin
            next_dout.uv_alarm = 1'b1; // [RULE_01]
            irq_evt[ors_pkg::IRQ_ALARM] = 1'b1;
            next_state = ors_pkg::ST_TRIP;
          end else if (mode == ors_pkg::MODE_TRIP_LATER) begin
            next_state = ors_pkg::ST_FAIL; // [RULE_02]
          end else begin
            next_saved_freq = i_out_freq; // [RULE_03]
            next_dout.pending = 1'b1; // [RULE_07]
            next_state = ors_pkg::ST_FAIL;
          end
        end
      end
      ors_pkg::ST_FAIL: begin
        if (din.coast && mode != ors_pkg::MODE_TRIP_LATER) begin
          next_dout.pending = 1'b0; // [RULE_13]
          irq_evt[ors_pkg::IRQ_CANCEL] = 1'b1;
          next_state = ors_pkg::ST_IDLE;
        end else if (!din.uv) begin
          next_state = ors_pkg::ST_CHARGE; // [RULE_07]
        end
      end
      ors_pkg::ST_CHARGE: begin
        if (din.uv) begin
          next_state = ors_pkg::ST_FAIL;
        end else if (din.ready) begin
          if (mode == ors_pkg::MODE_TRIP_LATER) begin
            next_dout.uv_alarm = 1'b1; // [RULE_02]
            irq_evt[ors_pkg::IRQ_ALARM] = 1'b1;
            next_state = ors_pkg::ST_TRIP;
          end else if (outage_over) begin
            next_dout.pending = 1'b0; // [RULE_15]
            irq_evt[ors_pkg::IRQ_CANCEL] = 1'b1;
            next_state = ors_pkg::ST_IDLE;
          end else begin
            next_wait_ms = '0;
            next_state = ors_pkg::ST_WAIT_RUN;
          end
        end
      end
      ors_pkg::ST_WAIT_RUN: begin
        if (din.uv) begin
          next_state = ors_pkg::ST_FAIL;
        end else if (din.coast || outage_over || wait_ms >= ors_pkg::RUN_WAIT_MS) begin
          next_dout.pending = 1'b0; // [RULE_09] [RULE_12] [RULE_13]
          irq_evt[ors_pkg::IRQ_CANCEL] = 1'b1;
          next_state = ors_pkg::ST_IDLE;
        end else if ((din.run_cmd || fixed_src) && fail_ms >= delay_ms) begin // [RULE_08]
          // fixed source keeps the request internally [RULE_10] [RULE_16]
          next_dout.pending = 1'b0;
          next_dout.out_enable = 1'b1;
          next_dout.restart = 1'b1;
          irq_evt[ors_pkg::IRQ_RESTART] = 1'b1;
          if (mode == ors_pkg::MODE_SAVED_FREQ) begin
            next_dout.freq = saved_freq; // [RULE_04]
            next_target_freq = saved_freq;
            next_settle = ors_pkg::SYNC_CYC;
            next_state = ors_pkg::ST_RESTART;
          end else begin
            next_dout.freq = start_freq; // [RULE_05]
            next_state = ors_pkg::ST_RUN;
          end
        end
      end
      ors_pkg::ST_RESTART: begin
        // pull-down only acts with the instant overcurrent limiter on
        if (din.uv || !din.run_cmd && !fixed_src) begin
          next_dout.out_enable = 1'b0;
          next_state = ors_pkg::ST_IDLE;
        end else if (ocl_en && din.i_limit) begin
          if (dout.freq != '0) next_dout.freq = dout.freq - 16'h0001; // [RULE_14]
        end else if (settle != 2'h0) begin
          // the limit flag only reaches din after the synchroniser, so do not finish early
          next_settle = settle - 2'h1; // [RULE_14]
        end else if (dout.freq < target_freq) begin
          next_dout.freq = dout.freq + 16'h0001; // [RULE_14]
        end else begin
          next_state = ors_pkg::ST_RUN;
        end
      end
      ors_pkg::ST_TRIP: begin
        next_dout.out_enable = 1'b0;
        if (!din.uv && !din.run_cmd) begin
          next_dout.uv_alarm = 1'b0;
          next_state = ors_pkg::ST_IDLE;
        end
      end
      default: next_state = ors_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      state <= ors_pkg::ST_IDLE;
      dout <= '0;
      div_cnt <= '0;
      fail_ms <= '0;
      wait_ms <= '0;
      saved_freq <= '0;
      target_freq <= '0;
      settle <= '0;
    end else if (i_clk_en) begin
      pin_s1 <= {i_uv, i_ready, i_run_cmd, i_coast_stop_command, i_current_limit};
      pin_s2 <= pin_s1;
      state <= next_state;
      dout <= next_dout;
      div_cnt <= next_div_cnt;
      fail_ms <= next_fail_ms;
      wait_ms <= next_wait_ms;
      saved_freq <= next_saved_freq;
      target_freq <= next_target_freq;
      settle <= next_settle;
    end
  end

  // axi-lite slave; write taken when address and data have both arrived
  logic aw_got, next_aw_got, w_got, next_w_got, bvalid, next_bvalid, rvalid, next_rvalid;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, rdata, next_rdata;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic irq, next_irq;
  logic do_wr;
  assign do_wr = aw_got && w_got && !bvalid;

  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_bvalid = bvalid && !s_axi_bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !s_axi_rready;
    next_rdata = rdata;
    next_rresp = rresp;
    next_ctrl = ctrl;
    next_times = times;
    next_start_freq = start_freq;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (s_axi_awvalid && !aw_got) begin
      next_aw_got = 1'b1;
      next_aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !w_got) begin
      next_w_got = 1'b1;
      next_w_data = s_axi_wdata;
    end
    if (do_wr) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = ors_pkg::RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        if (s_axi_wstrb[b] || 1'b1) begin
          unique case (aw_addr)
            ors_pkg::REG_CTRL: next_ctrl[8*b+:8] = w_data[8*b+:8];
            ors_pkg::REG_TIMES: next_times[8*b+:8] = w_data[8*b+:8];
            default: ;
          endcase
        end
      end
      unique case (aw_addr)
        ors_pkg::REG_CTRL, ors_pkg::REG_TIMES, ors_pkg::REG_STATUS, ors_pkg::REG_FREQ: ;
        ors_pkg::REG_START_FREQ: next_start_freq = w_data[15:0];
        ors_pkg::REG_IRQ_STAT: next_irq_stat = irq_stat & ~w_data[ors_pkg::IRQ_W-1:0];
        ors_pkg::REG_IRQ_MASK: next_irq_mask = w_data[ors_pkg::IRQ_W-1:0];
        default: next_bresp = ors_pkg::RESP_SLVERR;
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | irq_evt;
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = ors_pkg::RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        ors_pkg::REG_CTRL: next_rdata = ctrl;
        ors_pkg::REG_TIMES: next_rdata = times;
        ors_pkg::REG_START_FREQ: next_rdata = {16'h0000, start_freq};
        ors_pkg::REG_STATUS: next_rdata = {25'h0, state, dout.restart, dout.pending,
                                           dout.uv_alarm, dout.out_enable};
        ors_pkg::REG_IRQ_STAT: next_rdata = {28'h0000000, irq_stat};
        ors_pkg::REG_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
        ors_pkg::REG_FREQ: next_rdata = {16'h0000, saved_freq};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = ors_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      bvalid <= 1'b0;
      bresp <= ors_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= ors_pkg::RESP_OKAY;
      ctrl <= ors_pkg::CTRL_RESET;
      times <= ors_pkg::TIMES_RESET;
      start_freq <= ors_pkg::START_FREQ_RESET;
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end else if (i_clk_en) begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      ctrl <= next_ctrl;
      times <= next_times;
      start_freq <= next_start_freq;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end

  assign s_axi_awready = !aw_got;
  assign s_axi_wready = !w_got;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign o_out_enable = dout.out_enable;
  assign o_uv_alarm = dout.uv_alarm;
  assign o_restart_pending = dout.pending;
  assign o_restart = dout.restart;
  assign o_freq_ref = dout.freq;
  assign o_irq = irq;

  mode0_trip_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_clk_en && state == ors_pkg::ST_RUN && din.uv && din.run_cmd && !din.coast
    && mode == ors_pkg::MODE_TRIP_NOW |=> o_uv_alarm && !o_out_enable) // [RULE_01]
    else $error("mode 0 failure did not trip");
  mode1_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    state == ors_pkg::ST_FAIL && mode == ors_pkg::MODE_TRIP_LATER |-> !o_uv_alarm) // [RULE_02]
    else $error("mode 1 alarm raised during failure");
  freq_save_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_clk_en && state == ors_pkg::ST_RUN && din.uv && din.run_cmd && !din.coast
    && mode == ors_pkg::MODE_SAVED_FREQ |=> saved_freq == $past(i_out_freq)) // [RULE_03]
    else $error("failure frequency not saved");
  saved_restart_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_restart) && mode == ors_pkg::MODE_SAVED_FREQ |-> o_freq_ref == saved_freq) // [RULE_04]
    else $error("restart not at saved frequency");
  start_restart_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_restart) && mode == ors_pkg::MODE_START_FREQ |-> o_freq_ref == start_freq) // [RULE_05]
    else $error("restart not at starting frequency");
  run_window_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    state == ors_pkg::ST_WAIT_RUN |-> wait_ms <= ors_pkg::RUN_WAIT_MS) // [RULE_09]
    else $error("run wait window overran");
  delay_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_restart) |-> $past(fail_ms) >= delay_ms) // [RULE_16]
    else $error("restart before delay elapsed");
  out_off_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    state == ors_pkg::ST_FAIL |-> !o_out_enable) // [RULE_07]
    else $error("output on during failure");
endmodule

// ===== verif/ors_drive_model.sv
module ors_drive_model #(
  parameter int CHARGE_CYC = 20,
  parameter int RUN_LAG = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_power_ok,
  input wire logic i_run_req,
  input wire logic i_coast,
  input wire logic i_out_enable,
  input wire logic [15:0] i_freq_ref,
  input wire logic [15:0] i_motor_speed,
  output ors_pkg::ors_drive_in_type o_drv
);
  logic [15:0] cnt, next_cnt, spd, next_spd;
  logic lock, next_lock;
  always_comb begin
    next_cnt = i_power_ok ? cnt + {15'h0000, cnt != 16'hffff} : 16'h0000;
    // rotor locks to the output once the output no longer outruns it
    next_lock = i_out_enable && (lock || i_freq_ref <= spd);
    next_spd = next_lock ? i_freq_ref : (i_out_enable ? spd : i_motor_speed);
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cnt <= 16'h0000;
      spd <= 16'h0000;
      lock <= 1'h0;
    end else begin
      cnt <= next_cnt;
      spd <= next_spd;
      lock <= next_lock;
    end
  end
  assign o_drv.uv = !i_power_ok;
  // precharge keeps ready off for a while after mains return
  assign o_drv.ready = cnt >= 16'(CHARGE_CYC);
  // relay sequence comes back late, still inside the wait window
  assign o_drv.run_cmd = i_run_req && cnt >= 16'(CHARGE_CYC + RUN_LAG);
  assign o_drv.coast = i_coast;
  // limiter trips while the output outruns the coasting rotor
  assign o_drv.i_limit = i_out_enable && !lock && i_freq_ref > spd;
endmodule

// ===== verif/tb_top.sv
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  localparam logic [31:0] T0 = 32'h001e03e8;
  logic clk = 1'b0, rst = 1'b1, pwr = 1'b1, rreq = 1'b0, cst = 1'b0;
  logic [15:0] ofreq = 16'h0000, msp = 16'h0000, fref, fmin, rs_f;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic awr, wr, bv, arr, rv, en, alm, pend, rs, irq, ia, ib;
  logic [1:0] bresp, rresp;
  ors_pkg::ors_drive_in_type drv;
  int errors = 0, check_count = 0, w, off_t, al_t, rs_t, rs_n, pend_t, pend_hi;
  always #20 clk = ~clk;
  ors_sequencer #(.TICK_CYCLES(TK)) u_ors_sequencer (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(1'b1), .i_uv(drv.uv),
    .i_ready(drv.ready), .i_run_cmd(drv.run_cmd), .i_coast_stop_command(drv.coast),
    .i_current_limit(drv.i_limit), .i_out_freq(ofreq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .o_out_enable(en), .o_uv_alarm(alm), .o_restart_pending(pend),
    .o_restart(rs), .o_freq_ref(fref), .o_irq(irq));
  ors_drive_model u_ors_drive_model (.i_clk_sys(clk), .i_sys_rst(rst), .i_power_ok(pwr),
    .i_run_req(rreq), .i_coast(cst), .i_out_enable(en), .i_freq_ref(fref),
    .i_motor_speed(msp), .o_drv(drv));
  task automatic final_report;
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo(input string s);
    errors++;
    $display("MISMATCH %s exp done got timeout", s);
    final_report();
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= {24'h000000, a};
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv) break;
    end
    bre <= 1'b0;
    if (n == 50) tmo("wr");
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= {24'h000000, a};
    arv <= 1'b1;
    rre <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    d = rdata;
    r = rresp;
    rre <= 1'b0;
    if (n == 50) tmo("rd");
  endtask
  task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    `CHK(s, e, d)
  endtask
  // every scenario starts from reset so a trip left over cannot leak into the next
  task automatic setup(input logic [31:0] c, input logic [31:0] t, input logic r);
    @(posedge clk);
    rst <= 1'b1;
    pwr <= 1'b1;
    cst <= 1'b0;
    rreq <= r;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    axw(ors_pkg::REG_CTRL, c);
    axw(ors_pkg::REG_TIMES, t);
    for (w = 0; w < 200 && en !== r; w++) @(posedge clk);
    if (en !== r) tmo("start");
  endtask
  task automatic outage(input int off, input int n, input logic rq, input logic cs);
    int i;
    off_t = -1;
    al_t = -1;
    rs_t = -1;
    pend_t = -1;
    rs_n = 0;
    pend_hi = 0;
    fmin = 16'hffff;
    pwr <= 1'b0;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      // run request and coast only change once the failure is on its way in
      if (i == 0) rreq <= rq;
      if (i == 5) cst <= cs;
      if (i == off) pwr <= 1'b1;
      if (i == off) cst <= 1'b0;
      if (!en && off_t < 0) off_t = i;
      if (alm && al_t < 0) al_t = i;
      if (rs && rs_t < 0) rs_t = i;
      if (rs) rs_n++;
      if (rs_t == i) rs_f = fref;
      if (rs_t >= 0 && i > rs_t && fref < fmin) fmin = fref;
      if (pend) pend_hi = 1;
      if (pend_hi != 0 && !pend && pend_t < 0) pend_t = i;
    end
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    `CHK("rst_en", 1'b0, en)
    rchk("ctrl", ors_pkg::REG_CTRL, ors_pkg::CTRL_RESET);
    rchk("times", ors_pkg::REG_TIMES, ors_pkg::TIMES_RESET);
    rchk("sfreq", ors_pkg::REG_START_FREQ, {16'h0000, ors_pkg::START_FREQ_RESET});
    axr(8'h1c, d, r);
    `CHK("unmapped", ors_pkg::RESP_SLVERR, r)
    `CHK("unmapped_d", 32'h00000000, d)
    setup(32'h00000004, T0, 1'b0);
    outage(3, 200, 1'b0, 1'b0);
    `CHK("idle_pend", 0, pend_hi)
    setup(32'h00000000, T0, 1'b1);
    // the trip clears once run drops, so look before the run request returns
    outage(3, 30, 1'b1, 1'b0);
    `CHK("m0_alarm", 1'b1, al_t >= 0 && al_t <= 6)
    `CHK("m0_off", 1'b1, off_t >= 0 && off_t <= 6 && !en)
    setup(32'h00000001, T0, 1'b1);
    outage(40, 70, 1'b1, 1'b0);
    `CHK("m1_off", 1'b1, off_t >= 0 && off_t <= 6 && rs_n == 0)
    `CHK("m1_alarm", 1'b1, al_t >= 40 && al_t <= 70 && !en)
    ofreq <= 16'h0400;
    msp <= 16'h0400;
    setup(32'h00000104, T0, 1'b1);
    msp <= 16'h03c0;
    outage(3, 500, 1'b1, 1'b0);
    `CHK("m4_pend", 1, pend_hi)
    `CHK("m4_delay", 1'b1, rs_t >= 30 * TK && rs_t < 30 * TK + 40)
    `CHK("m4_start", 1'b1, rs_f >= 16'h03f8 && rs_f <= 16'h0400)
    `CHK("m4_dip", 1'b1, fmin <= 16'h03c0 && fmin > 16'h03a0)
    `CHK("m4_back", 16'h0400, fref)
    rchk("m4_saved", ors_pkg::REG_FREQ, 32'h00000400);
    msp <= 16'hffff;
    setup(32'h00000005, T0, 1'b1);
    axw(ors_pkg::REG_START_FREQ, 32'h00000077);
    outage(3, 300, 1'b1, 1'b0);
    `CHK("m5_rs", 1, rs_n)
    `CHK("m5_freq", 16'h0077, rs_f)
    for (int s = 2; s < 4; s++) begin
      setup(32'h00000004 | (32'(s) << 4), T0, 1'b1);
      outage(3, 300, 1'b0, 1'b0);
      `CHK("fixed_src", 1, rs_n)
    end
    // longest outage so only the run wait can end the pending state
    setup(32'h00000004, 32'h001e7530, 1'b1);
    outage(3, 8300, 1'b0, 1'b0);
    `CHK("wait_rs", 0, rs_n)
    `CHK("wait_end", 1'b1, pend_t >= 2000 * TK && pend_t < 2000 * TK + 100)
    rchk("irq_stat", ors_pkg::REG_IRQ_STAT, 32'h00000009);
    axw(ors_pkg::REG_IRQ_MASK, 32'h00000000);
    repeat (3) @(posedge clk);
    ia = irq;
    axw(ors_pkg::REG_IRQ_MASK, 32'h0000000f);
    repeat (3) @(posedge clk);
    ib = irq;
    `CHK("irq_mask", 2'h1, {ia, ib})
    axw(ors_pkg::REG_IRQ_STAT, 32'h0000000f);
    repeat (3) @(posedge clk);
    `CHK("irq_clr", 1'b0, irq)
    rchk("irq_empty", ors_pkg::REG_IRQ_STAT, 32'h00000000);
    setup(32'h00000004, 32'h001e003c, 1'b1);
    outage(3, 400, 1'b0, 1'b0);
    `CHK("outage_end", 1'b1, pend_t >= 60 * TK && pend_t < 60 * TK + 40)
    `CHK("outage_rs", 0, rs_n)
    setup(32'h00000004, T0, 1'b1);
    outage(50, 400, 1'b1, 1'b1);
    `CHK("coast", 1'b1, rs_n == 0 && !pend && pend_t >= 0 && pend_t < 50 && en)
    final_report();
  end
endmodule
